/* fdccmd_pkg.sv */
// constants and types for the floppy command interpreter block
package fdccmd_pkg;

    // opcode low five bits
    localparam logic [4:0] FDCCMD_OPC_READ_ID   = 5'h0a;
    localparam logic [4:0] FDCCMD_OPC_VERIFY    = 5'h16;
    localparam logic [4:0] FDCCMD_OPC_WRITE     = 5'h05;
    localparam logic [4:0] FDCCMD_OPC_WRITE_DEL = 5'h09;

    // opcode and drive byte fields
    localparam int FDCCMD_OPC_MSB     = 4;
    localparam int FDCCMD_BIT_MULTI   = 7;
    localparam int FDCCMD_BIT_DENSITY = 6;
    localparam int FDCCMD_BIT_SKIP    = 5;
    localparam int FDCCMD_BIT_COUNT   = 7;
    localparam int FDCCMD_BIT_HEAD    = 2;
    localparam int FDCCMD_BIT_DRV_HI  = 1;
    localparam int FDCCMD_BIT_DRV_LO  = 0;

    // command byte positions
    localparam int FDCCMD_IDX_OPC  = 0;
    localparam int FDCCMD_IDX_DRV  = 1;
    localparam int FDCCMD_IDX_CYL  = 2;
    localparam int FDCCMD_IDX_HEAD = 3;
    localparam int FDCCMD_IDX_SEC  = 4;
    localparam int FDCCMD_IDX_SIZE = 5;
    localparam int FDCCMD_IDX_LAST = 6;
    localparam int FDCCMD_IDX_GAP  = 7;
    localparam int FDCCMD_IDX_DLEN = 8;
    localparam int FDCCMD_CMD_MAX  = 9;

    // byte counts
    localparam logic [3:0] FDCCMD_LEN_READ_ID = 4'h2;
    localparam logic [3:0] FDCCMD_LEN_XFER    = 4'h9;
    localparam logic [2:0] FDCCMD_RES_LEN     = 3'h7;
    localparam logic [2:0] FDCCMD_RES_LEN_INV = 3'h1;
    localparam int         FDCCMD_RES_MAX     = 7;

    // status for an unknown opcode
    localparam logic [7:0] FDCCMD_STAT_INVALID = 8'h80;

    typedef enum logic [1:0] {
        FDCCMD_OP_READ_ID   = 2'h0,
        FDCCMD_OP_VERIFY    = 2'h1,
        FDCCMD_OP_WRITE     = 2'h2,
        FDCCMD_OP_WRITE_DEL = 2'h3
    } fdccmd_op_t;

    typedef enum logic [2:0] {
        FDCCMD_ST_CMD  = 3'h1,
        FDCCMD_ST_EXEC = 3'h2,
        FDCCMD_ST_RES  = 3'h4
    } fdccmd_state_t;

endpackage : fdccmd_pkg

/* fdccmd_top.sv */
// command, execution and result phase sequencer for id, verify and write commands
`timescale 1ns/100ps
module fdccmd_top
    import fdccmd_pkg::*;
(
    // clock and reset
    input  wire logic       clock,
    input  wire logic       arst_n,
    // host command and result bytes
    input  wire logic       cmd_wr,
    input  wire logic [7:0] cmd_byte,
    output logic            cmd_ready,
    input  wire logic       res_rd,
    output logic [7:0]      res_byte,
    output logic            res_avail,
    // host write data
    input  wire logic       wdata_wr,
    input  wire logic [7:0] wdata_byte,
    output logic            wdata_req,
    // to the disk engine
    output logic            op_start,
    output logic [1:0]      op_kind,
    output logic            multi_track_flag,
    output logic            double_density_flag,
    output logic            skip_deleted_flag,
    output logic            enable_count_flag,
    output logic            head_select,
    output logic            drive_select_hi,
    output logic            drive_select_lo,
    output logic [7:0]      cyl_num,
    output logic [7:0]      head_num,
    output logic [7:0]      sector_num,
    output logic [7:0]      size_code,
    output logic [7:0]      last_sector_on_track,
    output logic [7:0]      gap_length,
    output logic [7:0]      data_length,
    output logic            skip_sector,
    output logic [7:0]      disk_byte,
    output logic            disk_byte_valid,
    // from the disk engine
    input  wire logic       id_found,
    input  wire logic       id_crc_ok,
    input  wire logic       id_deleted,
    input  wire logic [7:0] id_cyl,
    input  wire logic [7:0] id_head,
    input  wire logic [7:0] id_sector,
    input  wire logic [7:0] id_size,
    input  wire logic       disk_byte_req,
    input  wire logic       op_done,
    input  wire logic [7:0] result_status_a,
    input  wire logic [7:0] result_status_b,
    input  wire logic [7:0] result_status_c
);

    ////////////////////////////////////////////////////////////////////////////
    fdccmd_state_t state_q;
    fdccmd_op_t    op_q;
    logic [7:0]    cmd_q [FDCCMD_CMD_MAX];
    logic [7:0]    res_q [FDCCMD_RES_MAX];
    logic [3:0]    cnt_q;
    logic [2:0]    res_idx_q;
    logic [2:0]    res_len_q;
    logic          got_id_q;
    logic [7:0]    cur_c_q;
    logic [7:0]    cur_h_q;
    logic [7:0]    cur_r_q;
    logic [7:0]    cur_n_q;
    logic          cmd_ready_q;
    logic [7:0]    res_byte_q;
    logic          res_avail_q;
    logic          wdata_req_q;
    logic          op_start_q;
    logic          multi_q;
    logic          density_q;
    logic          skip_q;
    logic          count_q;
    logic          skip_sector_q;
    logic [7:0]    disk_byte_q;
    logic          disk_byte_valid_q;

    ////////////////////////////////////////////////////////////////////////////
    wire logic [4:0] opc_field   = cmd_byte[FDCCMD_OPC_MSB:0];
    wire logic       hit_read_id = (opc_field == FDCCMD_OPC_READ_ID);
    wire logic       hit_verify  = (opc_field == FDCCMD_OPC_VERIFY);
    wire logic       hit_write   = (opc_field == FDCCMD_OPC_WRITE);
    wire logic       hit_wdel    = (opc_field == FDCCMD_OPC_WRITE_DEL);
    wire logic       op_known    = hit_read_id | hit_verify | hit_write | hit_wdel;
    wire fdccmd_op_t op_dec      = hit_read_id ? FDCCMD_OP_READ_ID :
                                   hit_verify  ? FDCCMD_OP_VERIFY  :
                                   hit_write   ? FDCCMD_OP_WRITE   : FDCCMD_OP_WRITE_DEL;
    wire logic       in_cmd      = (state_q == FDCCMD_ST_CMD);
    wire logic       in_exec     = (state_q == FDCCMD_ST_EXEC);
    wire logic       in_res      = (state_q == FDCCMD_ST_RES);
    wire logic       first_byte  = (cnt_q == 4'h0);
    wire logic       is_read_id  = (op_q == FDCCMD_OP_READ_ID);
    wire logic       is_write    = (op_q == FDCCMD_OP_WRITE) | (op_q == FDCCMD_OP_WRITE_DEL);
    // nine bytes for verify and write, two for read id
    wire logic [3:0] need_len    = is_read_id ? FDCCMD_LEN_READ_ID : FDCCMD_LEN_XFER;
    wire logic [3:0] cnt_inc     = cnt_q + 4'h1;
    // bytes outside the command phase are dropped
    wire logic       take_byte   = cmd_wr & in_cmd;
    wire logic       last_byte   = take_byte & ~first_byte & (cnt_inc == need_len);
    wire logic       good_id     = in_exec & id_found & id_crc_ok;
    // only verify carries the skip bit
    wire logic       skip_hit    = good_id & skip_q & id_deleted;
    wire logic       res_next    = in_res & res_rd & res_avail_q;
    wire logic [2:0] res_inc     = res_idx_q + 3'h1;
    wire logic       res_last    = (res_inc == res_len_q);

    ////////////////////////////////////////////////////////////////////////////
    // phase sequencer
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            state_q     <= FDCCMD_ST_CMD;
            op_q        <= FDCCMD_OP_READ_ID;
            cnt_q       <= 4'h0;
            cmd_ready_q <= 1'b1;
            op_start_q  <= 1'b0;
            multi_q     <= 1'b0;
            density_q   <= 1'b0;
            skip_q      <= 1'b0;
            count_q     <= 1'b0;
        end else begin
            op_start_q <= 1'b0;
            case (state_q)
                FDCCMD_ST_CMD: begin
                    if (take_byte && first_byte) begin
                        if (op_known) begin
                            op_q      <= op_dec;
                            cnt_q     <= cnt_inc;
                            multi_q   <= cmd_byte[FDCCMD_BIT_MULTI] & ~hit_read_id;
                            density_q <= cmd_byte[FDCCMD_BIT_DENSITY];
                            skip_q    <= cmd_byte[FDCCMD_BIT_SKIP] & hit_verify;
                        end else begin
                            state_q     <= FDCCMD_ST_RES;
                            cmd_ready_q <= 1'b0;
                        end
                    end else if (take_byte) begin
                        cnt_q <= cnt_inc;
                        if (cnt_q == 4'(FDCCMD_IDX_DRV)) begin
                            count_q <= cmd_byte[FDCCMD_BIT_COUNT] & (op_q == FDCCMD_OP_VERIFY);
                        end
                        if (last_byte) begin
                            state_q     <= FDCCMD_ST_EXEC;
                            cmd_ready_q <= 1'b0;
                            op_start_q  <= 1'b1;
                        end
                    end
                end
                FDCCMD_ST_EXEC: begin
                    if (op_done) begin
                        state_q <= FDCCMD_ST_RES;
                    end
                end
                FDCCMD_ST_RES: begin
                    if (res_next && res_last) begin
                        state_q     <= FDCCMD_ST_CMD;
                        cnt_q       <= 4'h0;
                        cmd_ready_q <= 1'b1;
                    end
                end
                default: begin
                    state_q     <= FDCCMD_ST_CMD;
                    cnt_q       <= 4'h0;
                    cmd_ready_q <= 1'b1;
                end
            endcase
        end
    end

    // byte two keeps head and drive select bits
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < FDCCMD_CMD_MAX; i++) begin
                cmd_q[i] <= 8'h00;
            end
        end else if (take_byte && (op_known || !first_byte)) begin
            cmd_q[cnt_q] <= cmd_byte;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // id tracking during execution
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            got_id_q      <= 1'b0;
            cur_c_q       <= 8'h00;
            cur_h_q       <= 8'h00;
            cur_r_q       <= 8'h00;
            cur_n_q       <= 8'h00;
            skip_sector_q <= 1'b0;
        end else begin
            skip_sector_q <= 1'b0;
            if (last_byte) begin
                got_id_q <= 1'b0;
                // read id has no start id; zeros until a good field
                cur_c_q  <= is_read_id ? 8'h00 : cmd_q[FDCCMD_IDX_CYL];
                cur_h_q  <= is_read_id ? 8'h00 : cmd_q[FDCCMD_IDX_HEAD];
                cur_r_q  <= is_read_id ? 8'h00 : cmd_q[FDCCMD_IDX_SEC];
                cur_n_q  <= is_read_id ? 8'h00 : cmd_q[FDCCMD_IDX_SIZE];
            end else if (skip_hit) begin
                // tell the engine to pass this sector
                skip_sector_q <= 1'b1;
            end else if (good_id && !(is_read_id && got_id_q)) begin
                // read id keeps first good id, others latest
                got_id_q <= 1'b1;
                cur_c_q  <= id_cyl;
                cur_h_q  <= id_head;
                cur_r_q  <= id_sector;
                cur_n_q  <= id_size;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // result bytes
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            for (int i = 0; i < FDCCMD_RES_MAX; i++) begin
                res_q[i] <= 8'h00;
            end
            res_idx_q   <= 3'h0;
            res_len_q   <= FDCCMD_RES_LEN;
            res_byte_q  <= 8'h00;
            res_avail_q <= 1'b0;
        end else if (take_byte && first_byte && !op_known) begin
            res_q[0]    <= FDCCMD_STAT_INVALID;
            res_idx_q   <= 3'h0;
            res_len_q   <= FDCCMD_RES_LEN_INV;
            res_byte_q  <= FDCCMD_STAT_INVALID;
            res_avail_q <= 1'b1;
        end else if (in_exec && op_done) begin
            // status a, b, c then cylinder, head, sector, size
            res_q[0]    <= result_status_a;
            res_q[1]    <= result_status_b;
            res_q[2]    <= result_status_c;
            res_q[3]    <= cur_c_q;
            res_q[4]    <= cur_h_q;
            res_q[5]    <= cur_r_q;
            res_q[6]    <= cur_n_q;
            res_idx_q   <= 3'h0;
            res_len_q   <= FDCCMD_RES_LEN;
            res_byte_q  <= result_status_a;
            res_avail_q <= 1'b1;
        end else if (res_next) begin
            res_idx_q   <= res_inc;
            res_byte_q  <= res_last ? 8'h00 : res_q[res_inc];
            res_avail_q <= ~res_last;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // write data path; a new request in the taking cycle stays pending
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            wdata_req_q       <= 1'b0;
            disk_byte_q       <= 8'h00;
            disk_byte_valid_q <= 1'b0;
        end else begin
            disk_byte_valid_q <= 1'b0;
            // host bytes pass on, even alongside op_done
            if (wdata_wr && wdata_req_q) begin
                disk_byte_q       <= wdata_byte;
                disk_byte_valid_q <= 1'b1;
            end
            if (!in_exec || op_done) begin
                wdata_req_q <= 1'b0;
            end else if (is_write) begin
                // verify and read id never raise a request
                wdata_req_q <= disk_byte_req | (wdata_req_q & ~wdata_wr);
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign cmd_ready            = cmd_ready_q;
    assign res_byte             = res_byte_q;
    assign res_avail            = res_avail_q;
    assign wdata_req            = wdata_req_q;
    assign op_start             = op_start_q;
    assign op_kind              = op_q;
    assign multi_track_flag     = multi_q;
    assign double_density_flag  = density_q;
    assign skip_deleted_flag    = skip_q;
    assign enable_count_flag    = count_q;
    assign head_select          = cmd_q[FDCCMD_IDX_DRV][FDCCMD_BIT_HEAD];
    assign drive_select_hi      = cmd_q[FDCCMD_IDX_DRV][FDCCMD_BIT_DRV_HI];
    assign drive_select_lo      = cmd_q[FDCCMD_IDX_DRV][FDCCMD_BIT_DRV_LO];
    assign cyl_num              = cmd_q[FDCCMD_IDX_CYL];
    assign head_num             = cmd_q[FDCCMD_IDX_HEAD];
    assign sector_num           = cmd_q[FDCCMD_IDX_SEC];
    assign size_code            = cmd_q[FDCCMD_IDX_SIZE];
    assign last_sector_on_track = cmd_q[FDCCMD_IDX_LAST];
    assign gap_length           = cmd_q[FDCCMD_IDX_GAP];
    assign data_length          = cmd_q[FDCCMD_IDX_DLEN];
    assign skip_sector          = skip_sector_q;
    assign disk_byte            = disk_byte_q;
    assign disk_byte_valid      = disk_byte_valid_q;
endmodule : fdccmd_top

/* fdccmd_top_properties.sv */
// assertions on the ports of the floppy command sequencer
`timescale 1ns/100ps
module fdccmd_top_properties
    import fdccmd_pkg::*;
(
    input wire logic       clock, arst_n, cmd_ready, res_avail, res_rd, op_start,
    input wire logic       wdata_req, wdata_wr, disk_byte_valid, disk_byte_req,
    input wire logic       id_found, id_crc_ok, id_deleted, skip_deleted_flag,
    input wire logic       skip_sector, op_done,
    input wire logic [1:0] op_kind,
    input wire logic [7:0] res_byte, wdata_byte, disk_byte, result_status_a
);
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);
    // execution phase is neither taking commands nor offering results
    wire exec_w = !cmd_ready && !res_avail;

    start_leaves_cmd_a: assert property (op_start |-> !cmd_ready)
        else $error("op_start while command bytes still taken");
    res_enter_a: assert property ($rose(res_avail) |-> !cmd_ready)
        else $error("results offered during command phase");
    cmd_back_a: assert property ($fell(res_avail) |-> cmd_ready)
        else $error("command phase not back after last result");
    verify_nodata_a: assert property (!op_kind[1] && !cmd_ready |-> !wdata_req)
        else $error("host data requested by verify or read id");
    req_follow_a: assert property (disk_byte_req && exec_w && op_kind[1] && !op_done
        |=> wdata_req)
        else $error("drive request not passed to host");
    data_pass_a: assert property (wdata_wr && wdata_req
        |=> disk_byte_valid && disk_byte == $past(wdata_byte))
        else $error("host byte not passed to drive");
    skip_pulse_a: assert property (id_found && id_crc_ok && id_deleted && skip_deleted_flag
        && exec_w |=> skip_sector)
        else $error("deleted sector not skipped");
    skip_cause_a: assert property (skip_sector |-> $past(id_deleted))
        else $error("skip without deleted mark");
    first_status_a: assert property (op_done && exec_w
        |=> res_avail && res_byte == $past(result_status_a))
        else $error("first result byte is not status a");

    cover property (op_start && op_kind == FDCCMD_OP_VERIFY);
    cover property (skip_sector);
    cover property (disk_byte_valid);
endmodule : fdccmd_top_properties

bind fdccmd_top fdccmd_top_properties chk_u (.clock(clock), .arst_n(arst_n),
    .cmd_ready(cmd_ready), .res_avail(res_avail), .res_rd(res_rd), .op_start(op_start),
    .wdata_req(wdata_req), .wdata_wr(wdata_wr), .disk_byte_valid(disk_byte_valid),
    .disk_byte_req(disk_byte_req), .id_found(id_found), .id_crc_ok(id_crc_ok),
    .id_deleted(id_deleted), .skip_deleted_flag(skip_deleted_flag),
    .skip_sector(skip_sector), .op_done(op_done), .op_kind(op_kind), .res_byte(res_byte),
    .wdata_byte(wdata_byte), .disk_byte(disk_byte), .result_status_a(result_status_a));

/* fdccmd_engine_model.sv */
// behavioural disk engine on the sequencer's drive side
`timescale 1ns/100ps
module fdccmd_engine_model (
    // clock
    input  wire logic clock,
    // events towards the sequencer
    output logic       id_found, id_crc_ok, id_deleted, disk_byte_req, op_done,
    output logic [7:0] id_cyl, id_head, id_sector, id_size,
    output logic [7:0] result_status_a, result_status_b, result_status_c
);
    initial {id_found, id_crc_ok, id_deleted, disk_byte_req, op_done, id_cyl, id_head,
        id_sector, id_size, result_status_a, result_status_b, result_status_c} = '0;

    // each event rests one idle cycle so no line is driven twice in a step
    task automatic show_id(input logic [7:0] c, h, r, n, input logic ok, del);
        {id_cyl, id_head, id_sector, id_size, id_crc_ok, id_deleted} = {c, h, r, n, ok, del};
        id_found = 1'b1;
        @(posedge clock);
        #2;
        id_found = 1'b0;
        // stale id lines turned round so a late sample cannot match
        {id_cyl, id_head, id_sector, id_size, id_crc_ok, id_deleted} = ~{c, h, r, n, ok, del};
        @(posedge clock);
        #2;
    endtask : show_id

    task automatic req();
        disk_byte_req = 1'b1;
        @(posedge clock);
        #2;
        disk_byte_req = 1'b0;
        @(posedge clock);
        #2;
    endtask : req

    task automatic done(input logic [7:0] a, b, s);
        {result_status_a, result_status_b, result_status_c, op_done} = {a, b, s, 1'b1};
        @(posedge clock);
        #2;
        {result_status_a, result_status_b, result_status_c, op_done} = {~a, ~b, ~s, 1'b0};
        @(posedge clock);
        #2;
    endtask : done
endmodule : fdccmd_engine_model

/* tb_fdccmd_top.sv */
// self-checking bench for the floppy command sequencer
`timescale 1ns/100ps
module tb_fdccmd_top
    import fdccmd_pkg::*;
;
    logic       clock = 1'b0, arst_n = 1'b0, cmd_wr = 1'b0, res_rd = 1'b0, wdata_wr = 1'b0;
    logic [7:0] cmd_byte = 8'h00, wdata_byte = 8'h00, res_byte, disk_byte;
    logic       cmd_ready, res_avail, wdata_req, disk_byte_valid, hs, dsh, dsl;
    logic [1:0] kind;
    logic       multi, dens, skipf, cntf;
    logic [7:0] cyl, hd, sec, sz, lst, gap, dlen;
    wire  [31:0] mode_w = {26'h0, multi, dens, skipf, cntf, kind};
    wire        id_found, id_crc_ok, id_deleted, disk_byte_req, op_done;
    wire  [7:0] id_cyl, id_head, id_sector, id_size, st_a, st_b, st_c;
    logic [7:0] res_q[$], disk_q[$], cmdq[$];
    logic [31:0] seed = 32'h711a;
    int         errors = 0, check_count = 0;

    always #12.5 clock = ~clock;

    fdccmd_top dut_u (.clock(clock), .arst_n(arst_n), .cmd_wr(cmd_wr), .cmd_byte(cmd_byte),
        .cmd_ready(cmd_ready), .res_rd(res_rd), .res_byte(res_byte), .res_avail(res_avail),
        .wdata_wr(wdata_wr), .wdata_byte(wdata_byte), .wdata_req(wdata_req), .op_start(),
        .op_kind(kind), .multi_track_flag(multi), .double_density_flag(dens),
        .skip_deleted_flag(skipf), .enable_count_flag(cntf), .head_select(hs),
        .drive_select_hi(dsh), .drive_select_lo(dsl), .cyl_num(cyl), .head_num(hd),
        .sector_num(sec), .size_code(sz), .last_sector_on_track(lst), .gap_length(gap),
        .data_length(dlen), .skip_sector(), .disk_byte(disk_byte),
        .disk_byte_valid(disk_byte_valid), .id_found(id_found), .id_crc_ok(id_crc_ok),
        .id_deleted(id_deleted), .id_cyl(id_cyl), .id_head(id_head), .id_sector(id_sector),
        .id_size(id_size), .disk_byte_req(disk_byte_req), .op_done(op_done),
        .result_status_a(st_a), .result_status_b(st_b), .result_status_c(st_c));

    fdccmd_engine_model eng_u (.clock(clock), .id_found(id_found), .id_crc_ok(id_crc_ok),
        .id_deleted(id_deleted), .disk_byte_req(disk_byte_req), .op_done(op_done),
        .id_cyl(id_cyl), .id_head(id_head), .id_sector(id_sector), .id_size(id_size),
        .result_status_a(st_a), .result_status_b(st_b), .result_status_c(st_c));

    function automatic logic [7:0] rnd8();
        seed = {seed[30:0], seed[31] ^ seed[21] ^ seed[1] ^ seed[0]};
        return seed[7:0];
    endfunction : rnd8

    task automatic cmp_byte(input string what, input logic [7:0] exp, got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_byte

    task automatic cmp_param(input string what, input logic [31:0] exp, got);
        check_count++;
        if (got !== exp) begin
            errors++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp_param

    task automatic tally_and_finish();
        $display("checks %0d errors %0d", check_count, errors);
        if (errors == 0 && check_count > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask : tally_and_finish

    task automatic step();
        @(posedge clock);
        #2;
    endtask : step

    task automatic send_cmd();
        for (int i = 0; i < 200 && cmd_ready !== 1'b1; i++) step();
        while (cmdq.size() > 0) begin
            cmd_wr = 1'b1;
            cmd_byte = cmdq.pop_front();
            step();
        end
        cmd_wr = 1'b0;
    endtask : send_cmd

    task automatic read_res(input int n);
        repeat (n) begin
            for (int i = 0; i < 50 && res_avail !== 1'b1; i++) step();
            cmp_byte("result ready", 8'h01, {7'h00, res_avail});
            res_rd = 1'b1;
            step();
            res_rd = 1'b0;
            step();
        end
    endtask : read_res

    task automatic finish_op(input logic [7:0] c, h, r, n);
        logic [7:0] a, b, s;
        a = rnd8();
        b = rnd8();
        s = rnd8();
        res_q = {res_q, a, b, s, c, h, r, n};
        eng_u.done(a, b, s);
        read_res(7);
    endtask : finish_op

    ////////////////////////////////////////////////////////////////////////
    always @(posedge clock) begin
        if (res_rd && res_avail) cmp_byte("result byte", res_q.pop_front(), res_byte);
        if (disk_byte_valid) cmp_byte("disk byte", disk_q.pop_front(), disk_byte);
    end

    initial begin
        repeat (5000) @(posedge clock);
        errors++;
        tally_and_finish();
    end

    initial begin
        logic [7:0] c, h, r, n, drv, e, g, d;
        repeat (20) @(posedge clock);
        #2 arst_n = 1'b1;
        // read id keeps the first good id, bad crc and later ids ignored
        cmdq = {8'h4a, 8'h05};
        send_cmd();
        cmp_param("mode flags", 32'h10, mode_w);
        c = rnd8(); h = rnd8(); r = rnd8(); n = rnd8();
        eng_u.show_id(~c, h, r, n, 1'b0, 1'b0);
        eng_u.show_id(c, h, r, n, 1'b1, 1'b0);
        eng_u.show_id(rnd8(), h, ~r, n, 1'b1, 1'b0);
        finish_op(c, h, r, n);
        // verify with skip flag: deleted id passed over, no host data
        cmdq = {8'h36, 8'h81, rnd8(), rnd8(), rnd8(), 8'h02, rnd8(), rnd8(), rnd8()};
        send_cmd();
        cmp_param("mode flags", 32'h0d, mode_w);
        c = rnd8(); r = rnd8();
        eng_u.show_id(c, 8'h01, r, 8'h02, 1'b1, 1'b0);
        // deleted id last, so tracking it would show in the result
        eng_u.show_id(~c, 8'h01, ~r, 8'h02, 1'b1, 1'b1);
        eng_u.req();
        cmp_byte("verify data request", 8'h00, {7'h00, wdata_req});
        finish_op(c, 8'h01, r, 8'h02);
        // write and write deleted, with a stray command byte during execution
        for (int k = 0; k < 2; k++) begin
            drv = rnd8() & 8'h07;
            c = rnd8(); h = rnd8(); r = rnd8(); n = rnd8();
            e = rnd8(); g = rnd8(); d = rnd8();
            cmdq = {k ? 8'h49 : 8'hc5, drv, c, h, r, n, e, g, d};
            send_cmd();
            cmd_wr = 1'b1;
            cmd_byte = 8'h0a;
            step();
            cmd_wr = 1'b0;
            cmp_byte("drive bits", {5'h00, drv[2:0]}, {5'h00, hs, dsh, dsl});
            cmp_param("mode flags", k ? 32'h13 : 32'h32, mode_w);
            cmp_param("id params", {c, h, r, n}, {cyl, hd, sec, sz});
            cmp_param("track params", {8'h00, e, g, d}, {8'h00, lst, gap, dlen});
            repeat (3) begin
                eng_u.req();
                for (int i = 0; i < 20 && wdata_req !== 1'b1; i++) step();
                wdata_wr = 1'b1;
                wdata_byte = rnd8();
                disk_q.push_back(wdata_byte);
                step();
                wdata_wr = 1'b0;
            end
            if (k) begin
                r = rnd8();
                eng_u.show_id(c, h, r, n, 1'b1, 1'b0);
            end
            finish_op(c, h, r, n);
        end
        // unknown opcode answers with one status byte
        cmdq = {8'h10};
        send_cmd();
        res_q.push_back(FDCCMD_STAT_INVALID);
        read_res(1);
        repeat (5) step();
        cmp_byte("unmatched notes", 8'h00, 8'(res_q.size() + disk_q.size()));
        tally_and_finish();
    end
endmodule : tb_fdccmd_top
